// ===== rtl/adcdc_regs.vh
// Constants for the daisy-chain converter readout block.
// Assumes a single 25 MHz clock; included by bare name.
`ifndef ADCDC_REGS_VH
`define ADCDC_REGS_VH

// ----------------------------------------
// Timing
// ----------------------------------------
`define ADCDC_MCLK_NS 40
`define ADCDC_CONV_TIME_NS 1000
`define ADCDC_CONV_CYC ((`ADCDC_CONV_TIME_NS + `ADCDC_MCLK_NS - 1) / `ADCDC_MCLK_NS)

// ----------------------------------------
// Widths and sizes
// ----------------------------------------
`define ADCDC_RES_BITS 16
`define ADCDC_FIFO_DEPTH 8
`define ADCDC_FIFO_AW 3

// ----------------------------------------
// Reset values
// ----------------------------------------
`define ADCDC_OUT_RST 1'b0
`define ADCDC_WORD_RST 16'h0000
`define ADCDC_CNT_RST 8'h00
`define ADCDC_BITS_RST 5'h00

// ----------------------------------------
// State codes, one-hot
// ----------------------------------------
`define ADCDC_ST_IDLE 3'h1
`define ADCDC_ST_CONV 3'h2
`define ADCDC_ST_READ 3'h4

`endif

// ===== rtl/adcdc_readout.v
// Daisy-chain serial readout of a 16-bit sampling converter.
// Assumes trigger, chain input and serial clock come from pins
// of another domain; sample words arrive from the core on mclk.
`timescale 1ns/1ps
`default_nettype none
`include "adcdc_regs.vh"

// ----------------------------------------
// Sample FIFO
// ----------------------------------------
module adcdc_fifo #(
   parameter WIDTH = `ADCDC_RES_BITS,
   parameter DEPTH = `ADCDC_FIFO_DEPTH,
   parameter AW = `ADCDC_FIFO_AW
) (
   input wire mclk,
   input wire srst,
   input wire [WIDTH-1:0] inData,
   input wire inValid,
   output wire inReady,
   output wire [WIDTH-1:0] outData,
   output wire outValid,
   input wire outReady
);
   // DEPTH must be a power of two so the pointers wrap cleanly
   localparam [AW:0] FULL_CNT = DEPTH[AW:0];

   reg [WIDTH-1:0] mem_q [0:DEPTH-1];
   reg [AW-1:0] wrPtr_q;
   reg [AW-1:0] rdPtr_q;
   reg [AW:0] count_q;
   wire wrEn;
   wire rdEn;

   // Honest full and empty from the occupancy count
   assign inReady = (count_q != FULL_CNT);
   assign outValid = (count_q != {(AW+1){1'b0}});
   assign wrEn = inValid & inReady;
   assign rdEn = outValid & outReady;
   assign outData = mem_q[rdPtr_q];

   // Storage is plain flip-flops, no reset needed on data
   always @(posedge mclk) begin
      if (wrEn) begin
         mem_q[wrPtr_q] <= inData;
      end
   end

   // Pointers and count
   always @(posedge mclk) begin
      if (srst) begin
         wrPtr_q <= {AW{1'b0}};
         rdPtr_q <= {AW{1'b0}};
         count_q <= {(AW+1){1'b0}};
      end else begin
         if (wrEn) begin
            wrPtr_q <= wrPtr_q + 1'b1;
         end
         if (rdEn) begin
            rdPtr_q <= rdPtr_q + 1'b1;
         end
         if (wrEn && !rdEn) begin
            count_q <= count_q + 1'b1;
         end else if (rdEn && !wrEn) begin
            count_q <= count_q - 1'b1;
         end
      end
   end
endmodule // adcdc_fifo

// ----------------------------------------
// Readout top
// ----------------------------------------
module adcdc_readout #(
   parameter RES_BITS = `ADCDC_RES_BITS,
   parameter FIFO_DEPTH = `ADCDC_FIFO_DEPTH,
   parameter CONV_CYCLES = `ADCDC_CONV_CYC
) (
   input wire mclk,
   input wire srst,
   input wire convertTrigger,
   input wire serialChainIn,
   input wire serialClock,
   input wire [RES_BITS-1:0] sampleData,
   input wire sampleValid,
   output wire sampleReady,
   output wire serialResultOut,
   output wire convActive,
   output wire busyMode,
   output wire readDone
);
   localparam [2:0] ST_IDLE = `ADCDC_ST_IDLE;
   localparam [2:0] ST_CONV = `ADCDC_ST_CONV;
   localparam [2:0] ST_READ = `ADCDC_ST_READ;
   localparam integer CONV_LAST_I = CONV_CYCLES - 1;
   localparam [7:0] CONV_LAST = CONV_LAST_I[7:0];
   localparam integer BITS_I = RES_BITS;
   localparam [4:0] BITS_END = BITS_I[4:0];

   // Synchronisers: [0] first stage, [1] usable, [2] previous
   reg [2:0] cnvSync_q;
   reg [2:0] sdiSync_q;
   reg [2:0] sckSync_q;

   reg [2:0] state_q;
   reg [7:0] convCnt_q;
   reg [RES_BITS-1:0] sample_q;
   reg [RES_BITS-1:0] shift_q;
   reg busyMode_q;
   reg busyOwed_q;
   reg sdo_q;
   reg [4:0] bitCnt_q;

   wire cnvLevel;
   wire sdiLevel;
   wire sckLevel;
   wire cnvRise;
   wire sckFall;
   wire startConv;
   wire [RES_BITS-1:0] fifoData;
   wire fifoValid;

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------

   // Two flops before any logic; third stage for edges and the start-time chain check
   always @(posedge mclk) begin
      if (srst) begin
         cnvSync_q <= 3'h0;
         sdiSync_q <= 3'h0;
         sckSync_q <= 3'h0;
      end else begin
         cnvSync_q <= {cnvSync_q[1:0], convertTrigger};
         sdiSync_q <= {sdiSync_q[1:0], serialChainIn};
         sckSync_q <= {sckSync_q[1:0], serialClock};
      end
   end

   // Levels and edges from the settled stages only
   assign cnvLevel = cnvSync_q[1];
   assign sdiLevel = sdiSync_q[1];
   assign sckLevel = sckSync_q[1];
   assign cnvRise = cnvSync_q[1] & ~cnvSync_q[2];
   assign sckFall = ~sckSync_q[1] & sckSync_q[2];

   // The chain input is judged one sample before the trigger
   // edge, so a chain input tied to the trigger still reads low
   assign startConv = (state_q == ST_IDLE) & cnvRise & ~sdiSync_q[2];

   // ----------------------------------------
   // Sample buffering
   // ----------------------------------------

   // One word leaves per conversion, so a stalled host backs
   // the core up through sampleReady
   adcdc_fifo #(
      .WIDTH(RES_BITS),
      .DEPTH(FIFO_DEPTH),
      .AW(`ADCDC_FIFO_AW)
   ) u_fifo (
      .mclk(mclk),
      .srst(srst),
      .inData(sampleData),
      .inValid(sampleValid),
      .inReady(sampleReady),
      .outData(fifoData),
      .outValid(fifoValid),
      .outReady(startConv)
   );

   // ----------------------------------------
   // Conversion and shift control
   // ----------------------------------------

   // Main sequencer: idle, convert on timer, shift on clock falls
   always @(posedge mclk) begin
      if (srst) begin
         state_q <= ST_IDLE;
         convCnt_q <= `ADCDC_CNT_RST;
         sample_q <= `ADCDC_WORD_RST;
         shift_q <= `ADCDC_WORD_RST;
         busyMode_q <= 1'b0;
         busyOwed_q <= 1'b0;
         sdo_q <= `ADCDC_OUT_RST;
         bitCnt_q <= `ADCDC_BITS_RST;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (!cnvLevel && !sdiLevel) begin
                  sdo_q <= 1'b0;
               end
               if (startConv) begin
                  // Clock level at the edge picks the busy flag
                  busyMode_q <= sckLevel;
                  // An empty FIFO converts as a zero word
                  sample_q <= fifoValid ? fifoData : `ADCDC_WORD_RST;
                  convCnt_q <= `ADCDC_CNT_RST;
                  state_q <= ST_CONV;
               end
            end
            ST_CONV: begin
               // Timer only; serial clock and trigger are ignored
               convCnt_q <= convCnt_q + 8'h01;
               if (convCnt_q == CONV_LAST) begin
                  shift_q <= sample_q;
                  bitCnt_q <= `ADCDC_BITS_RST;
                  state_q <= ST_READ;
                  if (busyMode_q) begin
                     busyOwed_q <= 1'b1;
                     sdo_q <= 1'b1;
                  end else begin
                     sdo_q <= sample_q[RES_BITS-1];
                  end
               end
            end
            ST_READ: begin
               if (!cnvLevel) begin
                  // Trigger dropped: readout is over
                  busyOwed_q <= 1'b0;
                  state_q <= ST_IDLE;
               end else if (sckFall) begin
                  if (busyOwed_q) begin
                     // Upstream busy bit is not captured
                     busyOwed_q <= 1'b0;
                     sdo_q <= shift_q[RES_BITS-1];
                  end else begin
                     // Capture upstream bit, present next one
                     shift_q <= {shift_q[RES_BITS-2:0], sdiLevel};
                     sdo_q <= shift_q[RES_BITS-2];
                     if (bitCnt_q != BITS_END) begin
                        bitCnt_q <= bitCnt_q + 5'h01;
                     end
                  end
               end
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------

   // In readout the output changes only after a clock fall, so it is steady
   // through the following high and low phases
   assign serialResultOut = sdo_q;
   assign convActive = (state_q == ST_CONV);
   assign busyMode = busyMode_q;
   // Own word gone; the shifter now just relays upstream bits
   assign readDone = (state_q == ST_READ) & (bitCnt_q == BITS_END);
endmodule // adcdc_readout
`default_nettype wire

// ===== dv/adcdc_readout_sva.sv
// Pin-level assertions for the chain readout block.
// Bound from tb; conversion length comes in as a parameter.
`timescale 1ns/1ps
`default_nettype none
module adcdc_readout_sva #(
   parameter int CONV_CYCLES = 25
) (
   input wire logic mclk,
   input wire logic srst,
   input wire logic convertTrigger,
   input wire logic serialChainIn,
   input wire logic serialClock,
   input wire logic sampleValid,
   input wire logic sampleReady,
   input wire logic serialResultOut,
   input wire logic convActive,
   input wire logic busyMode,
   input wire logic readDone
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (srst);
   // Conversion length; saturates so a hang cannot wrap
   logic [7:0] convLen_q;
   always_ff @(posedge mclk) begin
      if (srst || !convActive) convLen_q <= 8'h00;
      else if (convLen_q != 8'hFF) convLen_q <= convLen_q + 8'h01;
   end
   // Pins pass two flops, so idle levels need a few cycles to show
   AST_IDLE_LOW:
      assert property ((!convertTrigger && !serialChainIn)[*5] |-> !serialResultOut) else $error("idle out high");
   AST_START:
      assert property ($rose(convActive) |-> $past(convertTrigger) && !$past(convertTrigger, 6)
         && !$past(serialChainIn, 6)) else $error("bad start");
   AST_CONV_LEN:
      assert property ($fell(convActive) |-> convLen_q == CONV_CYCLES) else $error("conv length");
   AST_BUSY_FLAG:
      assert property ($fell(convActive) && busyMode |-> serialResultOut) else $error("no busy flag");
   AST_MODE:
      assert property ($rose(convActive) |=> busyMode == $past(serialClock, 5)) else $error("mode wrong");
   AST_HOLD:
      assert property ((serialClock && convertTrigger)[*4] ##0 !$fell(convActive) |-> $stable(serialResultOut))
         else $error("out moved, clock high");
   AST_DONE:
      assert property (convActive |-> !readDone) else $error("done in conversion");
   AST_FULL:
      assert property ($fell(sampleReady) |-> $past(sampleValid)) else $error("ready fell, no push");
   cover property ($fell(convActive) && busyMode);
   cover property ($fell(convActive) && !busyMode);
   cover property (!sampleReady);
endmodule // adcdc_readout_sva
`default_nettype wire

// ===== dv/adcdc_host_model.sv
// Host of the chain: trigger, serial clock, upstream device output.
// Tasks are called at falling mclk edges, one after another.
`timescale 1ns/1ps
`default_nettype none
module adcdc_host_model (
   input wire logic mclk,
   input wire logic serialResultOut,
   output logic convertTrigger,
   output logic serialClock,
   output logic serialChainIn
);
   // Pins idle low; the clock stands still outside frames
   initial begin
      convertTrigger = 1'b0;
      serialClock = 1'b0;
      serialChainIn = 1'b0;
   end
   // Clock level picks the mode; chain level before and at the rise
   task automatic start(input logic busy, input logic lead, input logic lag);
      serialClock = busy;
      serialChainIn = lead;
      repeat (8) @(negedge mclk);
      convertTrigger = 1'b1; // shared line held to frame end
      serialChainIn = lag;
   endtask
   // One 320 ns period; read just before the fall, upstream moves after it
   task automatic pulse(input logic chain, output logic got);
      serialClock = 1'b1;
      repeat (4) @(negedge mclk);
      got = serialResultOut;
      serialClock = 1'b0;
      repeat (2) @(negedge mclk);
      serialChainIn = chain;
      repeat (2) @(negedge mclk);
   endtask
   // End of frame
   task automatic stop;
      convertTrigger = 1'b0;
      serialClock = 1'b0;
      serialChainIn = 1'b0;
      repeat (8) @(negedge mclk);
   endtask
endmodule // adcdc_host_model
`default_nettype wire

// ===== dv/tb.sv
// Self-checking bench for the chain readout block.
// Host model drives the pins; the bench feeds sample words.
`timescale 1ns/1ps
`default_nettype none
module tb;
   localparam logic [15:0] UP = 16'h6B2D; // upstream device word
   logic mclk = 1'b0;
   logic srst = 1'b1;
   logic sampleValid = 1'b0;
   logic [15:0] sampleData = 16'h0000;
   logic [15:0] w [0:7];
   wire logic convertTrigger, serialChainIn, serialClock, sampleReady;
   wire logic serialResultOut, convActive, busyMode, readDone;
   int fails = 0;
   int nTests = 0;
   // 25 MHz clock
   always #20 mclk = ~mclk;
   adcdc_host_model adcdc_host_model_i (.mclk(mclk), .serialResultOut(serialResultOut),
      .convertTrigger(convertTrigger), .serialClock(serialClock), .serialChainIn(serialChainIn));
   // Full-length conversion so clock activity fits inside it
   adcdc_readout #(.CONV_CYCLES(25)) adcdc_readout_i (.mclk(mclk), .srst(srst), .convertTrigger(convertTrigger),
      .serialChainIn(serialChainIn), .serialClock(serialClock), .sampleData(sampleData),
      .sampleValid(sampleValid), .sampleReady(sampleReady), .serialResultOut(serialResultOut),
      .convActive(convActive), .busyMode(busyMode), .readDone(readDone));
   task automatic close_out;
      $display("checks %0d mismatches %0d", nTests, fails);
      if (fails == 0 && nTests > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      nTests++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH %0t got %h want %h", $time, got, exp);
      end
   endtask
   // Bounded wait through one whole conversion
   task automatic conv_wait;
      int i;
      i = 0;
      while (convActive !== 1'b1 && i < 99) begin
         @(negedge mclk);
         i++;
      end
      while (convActive !== 1'b0 && i < 99) begin
         @(negedge mclk);
         i++;
      end
      if (i >= 99) begin
         fails++;
         $display("MISMATCH %0t conversion hung", $time);
         close_out();
      end
   endtask
   // Fill the sample buffer until it refuses
   task automatic t_fill;
      chk(sampleReady, 1'b1);
      for (int k = 0; k < 8; k++) begin
         w[k] = 16'h9C35 ^ {4{k[3:0]}};
         sampleData = w[k];
         sampleValid = 1'b1;
         @(negedge mclk);
      end
      sampleValid = 1'b0;
      chk(sampleReady, 1'b0);
   endtask
   // Busy frame of two devices, chain tied high with the trigger as an upstream flag
   task automatic t_busy;
      logic b;
      adcdc_host_model_i.start(1'b1, 1'b0, 1'b1);
      conv_wait();
      chk(busyMode, 1'b1);
      for (int k = 1; k <= 33; k++) begin
         adcdc_host_model_i.pulse(k <= 16 ? UP[16-k] : 1'b0, b);
         chk(b, k == 1 ? 1'b1 : (k <= 17 ? w[0][17-k] : UP[33-k]));
      end
      chk(readDone, 1'b1);
      adcdc_host_model_i.stop();
      chk(serialResultOut, 1'b0);
   endtask
   // Plain frame; a clock pulse lands inside the conversion
   task automatic t_plain;
      logic b;
      adcdc_host_model_i.start(1'b0, 1'b0, 1'b0);
      repeat (4) @(negedge mclk);
      adcdc_host_model_i.pulse(1'b0, b);
      conv_wait();
      chk(busyMode, 1'b0);
      chk(readDone, 1'b0);
      for (int k = 1; k <= 16; k++) begin
         adcdc_host_model_i.pulse(1'b1, b);
         chk(b, w[1][16-k]);
      end
      adcdc_host_model_i.stop();
   endtask
   // Chain input high before and at the trigger rise starts nothing
   task automatic t_refuse;
      adcdc_host_model_i.start(1'b0, 1'b1, 1'b1);
      repeat (40) begin
         @(negedge mclk);
         chk(convActive, 1'b0);
      end
      adcdc_host_model_i.stop();
      chk(sampleReady, 1'b1);
   endtask
   initial begin
      repeat (2) @(negedge mclk);
      srst = 1'b0;
      repeat (4) @(negedge mclk);
      t_fill();
      t_busy();
      t_plain();
      t_refuse();
      close_out();
   end
endmodule // tb
bind adcdc_readout adcdc_readout_sva #(.CONV_CYCLES(CONV_CYCLES)) adcdc_readout_sva_i (.mclk(mclk), .srst(srst),
   .convertTrigger(convertTrigger), .serialChainIn(serialChainIn), .serialClock(serialClock),
   .sampleValid(sampleValid), .sampleReady(sampleReady), .serialResultOut(serialResultOut),
   .convActive(convActive), .busyMode(busyMode), .readDone(readDone));
`default_nettype wire
